// file: ddr3_cycle_timer.v
// Down-counting wait timer loaded with a cycle count
`timescale 1ns/1ps
module ddr3_cycle_timer #(
   parameter W = 16
) (
   input  wire         mclk_i,
   input  wire         rst_n_i,
   input  wire         load_i,
   input  wire [W-1:0] count_i,
   output wire         done_o
);
   reg [W-1:0] cnt_reg;
   assign done_o = (cnt_reg == {W{1'b0}});
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= {W{1'b0}};
      end else if (load_i) begin
         cnt_reg <= count_i;
      end else if (!done_o) begin
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// file: ddr3_dev_model.sv
// Behavioural DDR3 device: refresh, self-refresh and power-down
`timescale 1ns/1ps
module ddr3_dev_model #(
   parameter A12_FAST = 1'b0
) (
   input  wire        ck_i,
   input  wire        ck_en_i,
   input  wire        cke_i,
   input  wire        reset_n_i,
   input  wire [3:0]  cmd_i,
   input  wire        banks_idle_i,
   output reg  [15:0] refs_o,
   output reg         sr_o,
   output reg         pd_o,
   output reg         dll_on_o,
   output reg         bufs_on_o,
   output reg         bad_o
);
   wire idle_cmd = cmd_i[3] || cmd_i == 4'h7;
   always @(posedge ck_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         refs_o <= 16'h0;
         {sr_o, pd_o, dll_on_o, bufs_on_o, bad_o} <= 5'b00110;
      end else if (sr_o) begin
         // Only CKE is looked at while self-refreshing
         if (cke_i) begin
            sr_o <= 1'b0;
            dll_on_o <= 1'b1;
         end
      end else if (pd_o) begin
         if (cke_i) begin
            {pd_o, dll_on_o, bufs_on_o} <= 3'b011;
         end
      end else if (cke_i && cmd_i == 4'h1) begin
         refs_o <= refs_o + 16'h1;
      end else if (cmd_i == 4'h1) begin
         refs_o <= refs_o + 16'h1;
         sr_o <= 1'b1;
         dll_on_o <= 1'b0;
      end else if (!cke_i) begin
         bad_o <= bad_o || !idle_cmd;
         pd_o <= 1'b1;
         bufs_on_o <= 1'b0;
         dll_on_o <= A12_FAST || !banks_idle_i;
      end
      // Clock may stop only in self-refresh
      if (reset_n_i && !ck_en_i && !sr_o) bad_o <= 1'b1;
   end
endmodule

// file: ddr3_pm_assertions.sv
// Pin-level checks of the refresh and power-state controller
`timescale 1ns/1ps
module ddr3_pm_assertions #(
   parameter REFI_CYC  = 195,
   parameter XSDLL_CYC = 512,
   parameter WRSRX_CYC = 512
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire cke_o,
   input wire cs_n_o,
   input wire ras_n_o,
   input wire cas_n_o,
   input wire we_n_o,
   input wire odt_o,
   input wire dll_ok_o,
   input wire wr_ok_o
);
   // ---------------------------------------------
   // Command decode and exit counters
   // ---------------------------------------------
   wire [3:0]  cmd = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
   wire        nop = cmd == 4'h7 || cmd == 4'hf;
   reg         cke_q;
   reg         sr_q;
   reg         owe_q;
   reg  [15:0] xs_cnt;
   reg  [15:0] gap;
   wire        ref_c = cke_q && cke_o && cmd == 4'h1;
   wire        sre_c = cke_q && !cke_o && cmd == 4'h1;
   wire        srx_c = sr_q && cke_o;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {cke_q, sr_q, owe_q} <= 3'b100;
         xs_cnt <= 16'hffff;
         gap <= 16'h0;
      end else begin
         cke_q <= cke_o;
         sr_q <= sre_c || (sr_q && !cke_o);
         owe_q <= srx_c || (owe_q && !ref_c);
         xs_cnt <= srx_c ? 16'h1 : xs_cnt + {15'h0, xs_cnt != 16'hffff};
         gap <= (ref_c || sr_q) ? 16'h0 : gap + 16'h1;
      end
   end
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   chk_trfc_nop: assert property (ref_c |=> nop [*4])
      else $error("command inside refresh cycle time");
   chk_sre_hold: assert property (sre_c |=> !cke_o)
      else $error("cke raised right after self-refresh entry");
   chk_odt_off: assert property (!odt_o)
      else $error("termination driven on");
   chk_cke_up_nop: assert property ($rose(cke_o) |-> nop ##1 cke_o)
      else $error("cke exit without nop or not held");
   chk_cke_down_cmd: assert property ($fell(cke_o) |-> nop || cmd == 4'h1)
      else $error("cke dropped with a live command");
   chk_xs_nop: assert property (srx_c |-> nop [*5])
      else $error("command inside self-refresh exit time");
   chk_wr_wait: assert property (wr_ok_o && !sr_q |-> xs_cnt >= WRSRX_CYC - 1)
      else $error("write allowed too early after exit");
   chk_dll_wait: assert property (dll_ok_o && !sr_q |-> xs_cnt >= XSDLL_CYC - 1)
      else $error("dll commands allowed too early");
   chk_ref_gap: assert property (gap <= 9 * REFI_CYC)
      else $error("refresh gap too long");
   chk_extra_ref: assert property (sre_c |-> !owe_q)
      else $error("self-refresh re-entry without extra refresh");
   cover property (ref_c);
   cover property (srx_c);
   cover property ($fell(cke_o) && nop);
endmodule

// file: ddr3_pm_consts.vh
// Constants for the DDR3 refresh and power-state controller
`ifndef DDR3_PM_CONSTS_VH
`define DDR3_PM_CONSTS_VH
// ---------------------------------------------------------------
// Clock and timing (ns; names ending in CK are in clock cycles)
// ---------------------------------------------------------------
`define CLK_PERIOD_NS  40
`define T_RP_NS        15
`define T_RFC_NS       160
`define T_REFI_NS      7800
`define T_CKE_NS       8
`define T_CKESR_NS     10
`define T_CKSRX_NS     10
`define T_XS_NS        170
`define T_XP_NS        8
`define T_XPDLL_NS     24
`define T_CPDED_CK     1
`define T_ODT_OFF_CK   8
`define T_XSDLL_CK     512
`define T_WR_SRX_CK    512
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ---------------------------------------------------------------
// Refresh credit and power-down duration limits
// ---------------------------------------------------------------
`define MAX_POSTPONE   8
`define MAX_PULLIN     8
`define MAX_REF_2REFI  16
`define MAX_PD_REFI    9
// ---------------------------------------------------------------
// Command pin codes {cs_n, ras_n, cas_n, we_n}
// ---------------------------------------------------------------
`define CMD_NOP        4'h7
`define CMD_DES        4'hf
`define CMD_REF        4'h1
`endif

// file: ddr3_ref_credit.v
// Signed refresh credit and two-tREFI window tracker
`timescale 1ns/1ps
`include "ddr3_pm_consts.vh"
module ddr3_ref_credit #(
   parameter REFI_CYC = 195
) (
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire        hold_i,
   input  wire        ref_i,
   output wire        must_ref_o,
   output wire        may_ref_o,
   output wire        owe_ref_o
);
   localparam [15:0] REFI_W = REFI_CYC;
   reg [15:0] tick_reg;
   reg signed [5:0] credit_reg;
   reg [4:0] win_cur_reg;
   reg [4:0] win_prev_reg;
   wire tick = (tick_reg == 16'h0000);
   wire [5:0] win_sum = {1'b0, win_cur_reg} + {1'b0, win_prev_reg};
   // Positive credit means refreshes owed
   assign must_ref_o = (credit_reg >= `MAX_POSTPONE);
   assign may_ref_o = (credit_reg > -`MAX_PULLIN) &&
                      (win_sum < `MAX_REF_2REFI);
   assign owe_ref_o = (credit_reg > 0);
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_reg <= 16'h0000;
         credit_reg <= 6'sh00;
         win_cur_reg <= 5'h00;
         win_prev_reg <= 5'h00;
      end else begin
         if (tick || hold_i) begin
            tick_reg <= REFI_W - 16'h0001;
         end else begin
            tick_reg <= tick_reg - 16'h0001;
         end
         // Credit frozen while in self-refresh
         if (!hold_i) begin
            if (tick && !ref_i) begin
               credit_reg <= credit_reg + 6'sh01;
            end else if (!tick && ref_i) begin
               credit_reg <= credit_reg - 6'sh01;
            end
         end
         if (tick) begin
            win_prev_reg <= win_cur_reg;
            win_cur_reg <= {4'h0, ref_i};
         end else if (ref_i) begin
            win_cur_reg <= win_cur_reg + 5'h01;
         end
      end
   end
endmodule

// file: ddr3_refresh_power_state.v
// Host controller for DDR3 refresh, self-refresh and power-down
`timescale 1ns/1ps
`include "ddr3_pm_consts.vh"
module ddr3_refresh_power_state #(
   parameter REFI_CYC  = `CYC_UP(`T_REFI_NS),
   parameter XSDLL_CYC = `T_XSDLL_CK,
   parameter WRSRX_CYC = `T_WR_SRX_CK
) (
   input  wire mclk_i,
   input  wire rst_n_i,
   input  wire banks_idle_i,
   input  wire busy_i,
   input  wire sr_req_i,
   input  wire pd_req_i,
   output reg  ck_en_o,
   output reg  cke_o,
   output reg  cs_n_o,
   output reg  ras_n_o,
   output reg  cas_n_o,
   output reg  we_n_o,
   output reg  odt_o,
   output reg  reset_n_o,
   output reg  grant_o,
   output reg  dll_ok_o,
   output reg  wr_ok_o,
   output reg  in_sr_o,
   output reg  in_pd_o
);
   // ---------------------------------------------------------------
   // Derived cycle counts
   // ---------------------------------------------------------------
   localparam [15:0] RP_CYC    = `CYC_UP(`T_RP_NS);
   localparam [15:0] RFC_CYC   = `CYC_UP(`T_RFC_NS);
   localparam [15:0] CKE_CYC   = `CYC_UP(`T_CKE_NS) + 1;
   localparam [15:0] CKESR_CYC = `CYC_UP(`T_CKESR_NS) + 1;
   localparam [15:0] CKSRX_CYC = `CYC_UP(`T_CKSRX_NS);
   localparam [15:0] XS_CYC    = `CYC_UP(`T_XS_NS);
   localparam [15:0] XP_CYC    = `CYC_UP(`T_XP_NS);
   localparam [15:0] XPDLL_CYC = `CYC_UP(`T_XPDLL_NS);
   localparam [15:0] ODT_CYC   = `T_ODT_OFF_CK;
   localparam [15:0] PD_MAX    = `MAX_PD_REFI * REFI_CYC - 4;
   localparam [15:0] XSDLL_W   = XSDLL_CYC;
   localparam [15:0] WRSRX_W   = WRSRX_CYC;
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam [9:0] S_IDLE  = 10'h001;
   localparam [9:0] S_PRE   = 10'h002;
   localparam [9:0] S_RFC   = 10'h004;
   localparam [9:0] S_ODT   = 10'h008;
   localparam [9:0] S_SR    = 10'h010;
   localparam [9:0] S_SRCK  = 10'h020;
   localparam [9:0] S_XS    = 10'h040;
   localparam [9:0] S_PD    = 10'h080;
   localparam [9:0] S_XP    = 10'h100;
   localparam [9:0] S_SRREF = 10'h200;

   reg  [9:0]  state_reg;
   reg  [9:0]  state_next;
   reg         ld;
   reg  [15:0] ld_val;
   reg  [3:0]  cmd;
   reg         cke_n;
   reg         ref_pulse;
   reg         extra_ref_reg;
   reg  [15:0] dll_cnt_reg;
   reg  [15:0] wr_cnt_reg;
   reg  [15:0] pd_cnt_reg;
   reg         sr_exit;
   wire        t_done;
   wire        must_ref;
   wire        may_ref;
   wire        owe_ref;

   ddr3_cycle_timer #(.W(16)) u_timer (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .load_i  (ld),
      .count_i (ld_val),
      .done_o  (t_done)
   );

   ddr3_ref_credit #(.REFI_CYC(REFI_CYC)) u_credit (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .hold_i     (state_reg == S_SR || state_reg == S_SRCK),
      .ref_i      (ref_pulse),
      .must_ref_o (must_ref),
      .may_ref_o  (may_ref),
      .owe_ref_o  (owe_ref)
   );

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      ld = 1'b0;
      ld_val = 16'h0000;
      cmd = `CMD_NOP;
      cke_n = 1'b1;
      ref_pulse = 1'b0;
      sr_exit = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (!busy_i && banks_idle_i &&
                (must_ref || (owe_ref && may_ref) ||
                 extra_ref_reg || sr_req_i)) begin
               // Banks idle: wait tRP before refresh
               state_next = S_PRE;
               ld = 1'b1;
               ld_val = RP_CYC;
            end else if (pd_req_i && !busy_i && !must_ref) begin
               cke_n = 1'b0;
               state_next = S_PD;
               ld = 1'b1;
               ld_val = CKE_CYC;
            end
         end
         S_PRE: begin
            if (t_done) begin
               if (sr_req_i && !extra_ref_reg && !must_ref) begin
                  state_next = S_ODT;
                  ld = 1'b1;
                  ld_val = ODT_CYC;
               end else begin
                  cmd = `CMD_REF;
                  ref_pulse = 1'b1;
                  state_next = S_RFC;
                  ld = 1'b1;
                  ld_val = RFC_CYC;
               end
            end
         end
         S_RFC: begin
            if (t_done) begin
               state_next = S_IDLE;
            end
         end
         S_ODT: begin
            if (t_done) begin
               cmd = `CMD_REF;
               cke_n = 1'b0;
               state_next = S_SR;
               ld = 1'b1;
               ld_val = CKESR_CYC;
            end
         end
         S_SR: begin
            cke_n = 1'b0;
            cmd = `CMD_DES;
            if (t_done && !sr_req_i) begin
               state_next = S_SRCK;
               ld = 1'b1;
               ld_val = CKSRX_CYC;
            end
         end
         S_SRCK: begin
            cke_n = 1'b0;
            cmd = `CMD_DES;
            if (t_done) begin
               cke_n = 1'b1;
               sr_exit = 1'b1;
               state_next = S_XS;
               ld = 1'b1;
               ld_val = XS_CYC;
            end
         end
         S_XS: begin
            if (t_done) begin
               state_next = S_IDLE;
            end
         end
         S_PD: begin
            cke_n = 1'b0;
            if (t_done && (!pd_req_i || must_ref ||
                pd_cnt_reg >= PD_MAX)) begin
               cke_n = 1'b1;
               state_next = S_XP;
               ld = 1'b1;
               ld_val = (XPDLL_CYC > CKE_CYC) ? XPDLL_CYC : CKE_CYC;
            end
         end
         S_XP: begin
            if (t_done) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers and pin outputs
   // ---------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= S_IDLE;
         cke_o <= 1'b1;
         ck_en_o <= 1'b1;
         {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `CMD_DES;
         odt_o <= 1'b0;
         reset_n_o <= 1'b0;
         grant_o <= 1'b0;
         dll_ok_o <= 1'b0;
         wr_ok_o <= 1'b0;
         in_sr_o <= 1'b0;
         in_pd_o <= 1'b0;
         extra_ref_reg <= 1'b0;
         dll_cnt_reg <= 16'h0000;
         wr_cnt_reg <= 16'h0000;
         pd_cnt_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cke_o <= cke_n;
         {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd;
         reset_n_o <= 1'b1;
         // Clock may stop only deep in self-refresh
         ck_en_o <= !(state_reg == S_SR && state_next == S_SR &&
                      t_done);
         in_sr_o <= (state_next == S_SR) || (state_next == S_SRCK);
         in_pd_o <= (state_next == S_PD);
         grant_o <= (state_next == S_IDLE) && (state_reg == S_IDLE);
         odt_o <= 1'b0;
         if (sr_exit) begin
            extra_ref_reg <= 1'b1;
         end else if (ref_pulse) begin
            extra_ref_reg <= 1'b0;
         end
         if (sr_exit) begin
            dll_cnt_reg <= XSDLL_W;
            wr_cnt_reg <= WRSRX_W;
         end else begin
            if (dll_cnt_reg != 16'h0000) begin
               dll_cnt_reg <= dll_cnt_reg - 16'h0001;
            end
            if (wr_cnt_reg != 16'h0000) begin
               wr_cnt_reg <= wr_cnt_reg - 16'h0001;
            end
         end
         dll_ok_o <= (dll_cnt_reg == 16'h0000) && !sr_exit &&
                     (state_next == S_IDLE);
         wr_ok_o <= (wr_cnt_reg == 16'h0000) && !sr_exit &&
                    (state_next == S_IDLE);
         if (state_next == S_PD) begin
            pd_cnt_reg <= pd_cnt_reg + 16'h0001;
         end else begin
            pd_cnt_reg <= 16'h0000;
         end
      end
   end
endmodule

// file: ddr3_refresh_power_state_tb.sv
// Self-checking bench for the refresh and power-state controller
`timescale 1ns/1ps
module ddr3_refresh_power_state_tb;
   localparam REFI = 40;
   localparam XSD  = 20;
   localparam WRS  = 20;
   typedef struct {
      logic sr, pd, busy, idle;
      int   wt;
      logic e_sr, e_pd, e_cke;
   } row_t;
   reg         mclk_i       = 1'b0;
   reg         rst_n_i      = 1'b0;
   reg         banks_idle_i = 1'b1;
   reg         busy_i       = 1'b0;
   reg         sr_req_i     = 1'b0;
   reg         pd_req_i     = 1'b0;
   wire        ck_en_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o;
   wire        odt_o, reset_n_o, grant_o, dll_ok_o, wr_ok_o;
   wire        in_sr_o, in_pd_o, m_sr, m_pd, m_dll, m_buf, m_bad;
   wire [15:0] refs;
   integer     errors    = 0;
   integer     cmp_count = 0;
   integer     cyc       = 0;
   integer     i, j, n0;
   row_t       rows [0:7];
   ddr3_refresh_power_state #(
      .REFI_CYC(REFI), .XSDLL_CYC(XSD), .WRSRX_CYC(WRS)
   ) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .banks_idle_i(banks_idle_i),
      .busy_i(busy_i), .sr_req_i(sr_req_i), .pd_req_i(pd_req_i),
      .ck_en_o(ck_en_o), .cke_o(cke_o), .cs_n_o(cs_n_o),
      .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
      .odt_o(odt_o), .reset_n_o(reset_n_o), .grant_o(grant_o),
      .dll_ok_o(dll_ok_o), .wr_ok_o(wr_ok_o), .in_sr_o(in_sr_o),
      .in_pd_o(in_pd_o)
   );
   ddr3_dev_model dev (
      .ck_i(mclk_i), .ck_en_i(ck_en_o), .cke_i(cke_o), .reset_n_i(reset_n_o),
      .cmd_i({cs_n_o, ras_n_o, cas_n_o, we_n_o}), .banks_idle_i(banks_idle_i),
      .refs_o(refs), .sr_o(m_sr), .pd_o(m_pd), .dll_on_o(m_dll),
      .bufs_on_o(m_buf), .bad_o(m_bad)
   );
   always #20 mclk_i = ~mclk_i;
   task chk(input logic ok, input string m);
      begin
         cmp_count = cmp_count + 1;
         if (ok !== 1'b1) begin
            errors = errors + 1;
            $display("Error %0t: %s", $time, m);
         end
      end
   endtask
   task cyc_wait(input integer n);
      begin
         repeat (n) @(posedge mclk_i);
         #1;
      end
   endtask
   task give_verdict;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         $display("Error %0t: run did not finish", $time);
         give_verdict;
      end
   end
   initial begin
      rows[0] = '{0, 0, 0, 1, 20, 0, 0, 1};
      rows[1] = '{0, 1, 0, 1, 20, 0, 1, 0};
      rows[2] = '{0, 0, 0, 1, 20, 0, 0, 1};
      rows[3] = '{1, 0, 0, 1, 40, 1, 0, 0};
      rows[4] = '{0, 0, 0, 1, 60, 0, 0, 1};
      rows[5] = '{0, 1, 1, 1, 20, 0, 0, 1};
      rows[6] = '{0, 1, 0, 0, 20, 0, 1, 0};
      rows[7] = '{0, 0, 0, 1, 20, 0, 0, 1};
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      cyc_wait(2);
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge mclk_i);
         sr_req_i <= rows[i].sr;
         pd_req_i <= rows[i].pd;
         busy_i <= rows[i].busy;
         banks_idle_i <= rows[i].idle;
         cyc_wait(rows[i].wt);
         chk(in_sr_o === rows[i].e_sr && m_sr === rows[i].e_sr, "sr");
         chk(in_pd_o === rows[i].e_pd && m_pd === rows[i].e_pd, "pd");
         chk(cke_o === rows[i].e_cke, "cke level");
         chk(m_buf === !rows[i].e_pd, "buffers");
         chk(m_dll === !(rows[i].e_sr || rows[i].e_pd && rows[i].idle), "dll");
         $display("Row %0d done", i);
      end
      n0 = refs;
      cyc_wait(2 * REFI);
      chk(refs - n0 <= 16, "too many refreshes");
      cyc_wait(8 * REFI);
      chk(refs - n0 >= 1 && refs - n0 <= 18, "refresh rate");
      $display("Refresh rate done");
      @(posedge mclk_i);
      sr_req_i <= 1'b1;
      for (j = 0; j < 200 && m_sr !== 1'b1; j = j + 1) cyc_wait(1);
      chk(m_dll === 1'b0, "dll on in sr");
      @(posedge mclk_i);
      sr_req_i <= 1'b0;
      for (j = 0; j < 200 && m_sr !== 1'b0; j = j + 1) cyc_wait(1);
      n0 = refs;
      @(posedge mclk_i);
      sr_req_i <= 1'b1;
      for (j = 0; j < 200 && m_sr !== 1'b1; j = j + 1) cyc_wait(1);
      chk(refs - n0 >= 2 && m_sr === 1'b1, "no extra refresh");
      @(posedge mclk_i);
      sr_req_i <= 1'b0;
      for (j = 0; j < 200 && cke_o !== 1'b1; j = j + 1) cyc_wait(1);
      cyc_wait(WRS - 3);
      chk(wr_ok_o === 1'b0 && dll_ok_o === 1'b0, "early grant");
      for (j = 0; j < 99 && (wr_ok_o & dll_ok_o) !== 1'b1; j = j + 1) cyc_wait(1);
      chk(wr_ok_o === 1'b1 && dll_ok_o === 1'b1, "no grant");
      $display("Self-refresh done");
      @(posedge mclk_i);
      pd_req_i <= 1'b1;
      cyc_wait(2);
      n0 = refs;
      cyc_wait(10 * REFI);
      chk(refs - n0 >= 1, "pd outlived refresh");
      for (j = 0; j < 200 && m_pd !== 1'b1; j = j + 1) cyc_wait(1);
      chk(m_bad === 1'b0, "illegal sequence before reset");
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      pd_req_i <= 1'b0;
      cyc_wait(1);
      chk(m_pd === 1'b0 && reset_n_o === 1'b0, "pd kept in reset");
      chk(cke_o === 1'b1 && {cs_n_o, ras_n_o, cas_n_o, we_n_o} === 4'hf, "rst");
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      cyc_wait(2);
      chk(reset_n_o === 1'b1 && odt_o === 1'b0, "release");
      chk(m_bad === 1'b0, "device saw illegal sequence");
      $display("Reset done");
      give_verdict;
   end
endmodule
bind ddr3_refresh_power_state ddr3_pm_assertions #(
   .REFI_CYC(REFI_CYC), .XSDLL_CYC(XSDLL_CYC), .WRSRX_CYC(WRSRX_CYC)
) u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cke_o(cke_o), .cs_n_o(cs_n_o),
   .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .odt_o(odt_o),
   .dll_ok_o(dll_ok_o), .wr_ok_o(wr_ok_o)
);
